// ===== sbrg_defs.vh
`ifndef SBRG_DEFS_VH
`define SBRG_DEFS_VH

// ****************************************
// register indices and byte addresses
// ****************************************
`define SBRG_IDX_DIVCTL      18'h0FF73
`define SBRG_IDX_CLKSRC      18'h0FF74
`define SBRG_IDX_STATUS      18'h0FF75
`define SBRG_ADDR_DIVCTL     18'h3FDCC
`define SBRG_ADDR_CLKSRC     18'h3FDD0
`define SBRG_ADDR_STATUS     18'h3FDD4

// ****************************************
// reset values
// ****************************************
`define SBRG_RST_DIVCTL      8'h00
`define SBRG_RST_CLKSRC      2'h0

// ****************************************
// field positions
// ****************************************
`define SBRG_DIV_CODE_LSB    0
`define SBRG_DIV_CODE_MSB    3
`define SBRG_PRE_SEL_LSB     4
`define SBRG_PRE_SEL_MSB     7
`define SBRG_CLK_HALVE_BIT   0
`define SBRG_CLK_INTSEL_BIT  1

// ****************************************
// codes and counts
// ****************************************
`define SBRG_DIV_BYPASS      4'hF
`define SBRG_DIV_BASE        5'h0F
`define SBRG_PRE_CODE_SLOW   4'h0
`define SBRG_PRE_CODE_FIRST  4'h5
`define SBRG_PRE_CODE_LAST   4'hE
`define SBRG_PRE_EXP_SLOW    4'hA
`define SBRG_PRE_WIDTH       10

`endif

// ===== sbrg_div5.v
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// 5-bit divide-by-(limit+1) counter
// ****************************************
module sbrg_div5 (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       arst_n_i,
  // control
  input  wire       tick_i,
  input  wire       clear_i,
  input  wire [4:0] limit_i,
  // result
  output wire       wrap_o,
  output reg  [4:0] count_o
);

  assign wrap_o = tick_i & (count_o == limit_i);

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_o <= 5'h00;
    end else if (clear_i) begin
      count_o <= 5'h00;
    end else if (wrap_o) begin
      count_o <= 5'h00;
    end else if (tick_i) begin
      count_o <= count_o + 5'h01;
    end
  end

endmodule

`default_nettype wire

// ===== sbrg_top.v
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "sbrg_defs.vh"

// Contract
// - divider control is 8-bit read/write, reset 00, whole-byte writes only
// - low nibble k 0..14 divides counter source by k+16
// - k all ones passes source undivided; only for synchronous 3-wire use
// - upper nibble picks system clock over 2^(n-1); 0 is n=11, 5..14 n=1..10
// - system clock is oscillator or half of it, per halving select
// - internal bit rate is system clock over 2^n times (k+16)
// - external pin bit rate is pin frequency over 2 times (k+16)
// - divide stage is a 5-bit counter on the selected source
// - clock select 0 takes external pin, 1 internal; 1 frees the pin
module sbrg_top (
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        arst_n_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // external clock pin
  input  wire        external_baud_clock_pin_i,
  // generator outputs
  output reg         baud_clk_o,
  output reg         baud_tick_o,
  output reg         ext_pin_free_o
);

  // ****************************************
  // registers
  // ****************************************
  reg  [7:0]  baud_divider_control;
  reg         osc_halving_select;
  reg         clk_int_select;
  reg         fxx_phase;
  reg  [9:0]  pre_cnt;
  reg         ext_pin_q;
  reg  [3:0]  pre_exp;
  reg         prescale_ok;

  // ****************************************
  // field decode
  // ****************************************
  wire [3:0] divisor_code;
  wire [3:0] prescale_code;
  wire       divisor_code_bit3;
  wire       divisor_code_bit2;
  wire       divisor_code_bit1;
  wire       divisor_code_bit0;
  wire       prescale_sel_bit3;
  wire       prescale_sel_bit2;
  wire       prescale_sel_bit1;
  wire       prescale_sel_bit0;

  assign divisor_code_bit3 = baud_divider_control[`SBRG_DIV_CODE_MSB];
  assign divisor_code_bit2 = baud_divider_control[`SBRG_DIV_CODE_LSB + 2];
  assign divisor_code_bit1 = baud_divider_control[`SBRG_DIV_CODE_LSB + 1];
  assign divisor_code_bit0 = baud_divider_control[`SBRG_DIV_CODE_LSB];
  assign prescale_sel_bit3 = baud_divider_control[`SBRG_PRE_SEL_MSB];
  assign prescale_sel_bit2 = baud_divider_control[`SBRG_PRE_SEL_LSB + 2];
  assign prescale_sel_bit1 = baud_divider_control[`SBRG_PRE_SEL_LSB + 1];
  assign prescale_sel_bit0 = baud_divider_control[`SBRG_PRE_SEL_LSB];
  assign divisor_code  = {divisor_code_bit3, divisor_code_bit2,
                          divisor_code_bit1, divisor_code_bit0};
  assign prescale_code = {prescale_sel_bit3, prescale_sel_bit2,
                          prescale_sel_bit1, prescale_sel_bit0};

  // ****************************************
  // apb decode
  // ****************************************
  wire        setup_phase;
  wire        access_done;
  wire        hit_divctl;
  wire        hit_clksrc;
  wire        hit_status;
  wire        hit_any;
  wire        wr_divctl;
  wire        wr_clksrc;

  assign setup_phase = psel_i & ~penable_i;
  assign access_done = psel_i & penable_i & pready_o;
  assign hit_divctl  = (paddr_i == {14'h0000, `SBRG_ADDR_DIVCTL});
  assign hit_clksrc  = (paddr_i == {14'h0000, `SBRG_ADDR_CLKSRC});
  assign hit_status  = (paddr_i == {14'h0000, `SBRG_ADDR_STATUS});
  assign hit_any     = hit_divctl | hit_clksrc | hit_status;
  // whole byte lane required
  assign wr_divctl   = access_done & pwrite_i & hit_divctl & pstrb_i[0];
  assign wr_clksrc   = access_done & pwrite_i & hit_clksrc & pstrb_i[0];

  // ****************************************
  // register file
  // ****************************************
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      baud_divider_control <= `SBRG_RST_DIVCTL;
    end else if (wr_divctl) begin
      baud_divider_control <= pwdata_i[7:0];
    end
  end

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {clk_int_select, osc_halving_select} <= `SBRG_RST_CLKSRC;
    end else if (wr_clksrc) begin
      osc_halving_select <= pwdata_i[`SBRG_CLK_HALVE_BIT];
      clk_int_select     <= pwdata_i[`SBRG_CLK_INTSEL_BIT];
    end
  end

  // ****************************************
  // status word
  // ****************************************
  wire [4:0] div_count;
  wire [7:0] status_word;

  assign status_word = {baud_clk_o, prescale_ok, div_count, fxx_phase};

  // ****************************************
  // apb answer, zero wait states
  // ****************************************
  reg  [31:0] next_rdata;
  reg         next_pready;
  reg         next_pslverr;
  reg  [31:0] next_prdata;

  always @* begin
    next_rdata = 32'h00000000;
    if (hit_divctl) begin
      next_rdata = {24'h000000, baud_divider_control};
    end else if (hit_clksrc) begin
      next_rdata = {30'h00000000, clk_int_select, osc_halving_select};
    end else if (hit_status) begin
      next_rdata = {24'h000000, status_word};
    end
  end

  always @* begin
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_prdata  = 32'h00000000;
    if (setup_phase) begin
      next_pready  = 1'b1;
      next_pslverr = ~hit_any;
      if (!pwrite_i) begin
        next_prdata = next_rdata;
      end
    end
  end

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= next_pready;
      pslverr_o <= next_pslverr;
      prdata_o  <= next_prdata;
    end
  end

  // ****************************************
  // system clock: oscillator or half of it
  // ****************************************
  wire fxx_tick;

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fxx_phase <= 1'b0;
    end else begin
      fxx_phase <= ~fxx_phase;
    end
  end

  assign fxx_tick = osc_halving_select | fxx_phase;

  // ****************************************
  // prescaler
  // ****************************************
  always @* begin
    pre_exp     = 4'h0;
    prescale_ok = 1'b0;
    case (prescale_code)
      `SBRG_PRE_CODE_SLOW: begin
        pre_exp     = `SBRG_PRE_EXP_SLOW;
        prescale_ok = 1'b1;
      end
      4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE: begin
        pre_exp     = prescale_code - `SBRG_PRE_CODE_FIRST;
        prescale_ok = 1'b1;
      end
      default: begin
        // prohibited codes stop the source
        pre_exp     = 4'h0;
        prescale_ok = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_cnt <= 10'h000;
    end else if (wr_divctl) begin
      pre_cnt <= 10'h000;
    end else if (fxx_tick) begin
      pre_cnt <= pre_cnt + 10'h001;
    end
  end

  wire [9:0] pre_mask;
  wire       int_tick;

  assign pre_mask = ~(10'h3FF << pre_exp);
  // fxx over 2^(n-1); the toggle supplies the last factor of two
  assign int_tick = fxx_tick & prescale_ok & ((pre_cnt & pre_mask) == pre_mask);

  // ****************************************
  // external pin source
  // ****************************************
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_pin_q <= 1'b0;
    end else begin
      ext_pin_q <= external_baud_clock_pin_i;
    end
  end

  wire ext_tick;

  // one tick per pin period; prescaler plays no part
  assign ext_tick = external_baud_clock_pin_i & ~ext_pin_q;

  // ****************************************
  // source select and 5-bit divider
  // ****************************************
  wire       src_tick;
  wire [4:0] div_limit;
  wire       div_wrap;

  assign src_tick  = clk_int_select ? int_tick : ext_tick;
  // bypass code divides by one
  assign div_limit = (divisor_code == `SBRG_DIV_BYPASS) ? 5'h00 :
                     ({1'b0, divisor_code} + `SBRG_DIV_BASE);

  sbrg_div5 u_div5 (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .tick_i    (src_tick),
    .clear_i   (wr_divctl),
    .limit_i   (div_limit),
    .wrap_o    (div_wrap),
    .count_o   (div_count)
  );

  // ****************************************
  // next output values
  // ****************************************
  reg         next_baud_clk;
  reg         next_baud_tick;
  reg         next_ext_pin_free;

  always @* begin
    next_baud_clk     = baud_clk_o;
    next_baud_tick    = 1'b0;
    next_ext_pin_free = clk_int_select;
    if (wr_divctl) begin
      // a write mid-transfer restarts the divider
      next_baud_clk = 1'b0;
    end else if (div_wrap) begin
      next_baud_clk  = ~baud_clk_o;
      next_baud_tick = 1'b1;
    end
  end

  // ****************************************
  // output flops
  // ****************************************
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      baud_clk_o     <= 1'b0;
      baud_tick_o    <= 1'b0;
      ext_pin_free_o <= 1'b0;
    end else begin
      baud_clk_o     <= next_baud_clk;
      baud_tick_o    <= next_baud_tick;
      ext_pin_free_o <= next_ext_pin_free;
    end
  end

endmodule

`default_nettype wire

// ===== sbrg_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbrg_defs.vh"
// ****************************************
// bus and generator checks
// ****************************************
module sbrg_top_sva (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  // apb
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  // pin and generator
  input  wire logic        external_baud_clock_pin_i,
  input  wire logic        baud_clk_o,
  input  wire logic        baud_tick_o,
  input  wire logic        ext_pin_free_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic wr     = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
  wire logic wr_div = wr && (paddr_i == {14'h0000, `SBRG_ADDR_DIVCTL});
  wire logic wr_src = wr && (paddr_i == {14'h0000, `SBRG_ADDR_CLKSRC});
  ready_timing_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h00000000)
    else $error("read data outside access");
  rdata_width_a: assert property (prdata_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  tick_toggle_a: assert property (baud_tick_o |-> baud_clk_o != $past(baud_clk_o))
    else $error("tick without toggle");
  clk_change_a: assert property ($changed(baud_clk_o) && !baud_tick_o |-> !baud_clk_o)
    else $error("baud clock moved without tick");
  div_clear_a: assert property (wr_div |-> ##[1:2] !baud_clk_o)
    else $error("divider write did not restart");
  pin_free_a: assert property ($changed(ext_pin_free_o) |-> $past(wr_src) || $past(wr_src, 2))
    else $error("pin free moved without write");
  cover property (baud_tick_o);
  cover property (pslverr_o);
  cover property ($rose(ext_pin_free_o));
endmodule

bind sbrg_top sbrg_top_sva sbrg_top_sva_inst (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .external_baud_clock_pin_i(external_baud_clock_pin_i), .baud_clk_o(baud_clk_o),
  .baud_tick_o(baud_tick_o), .ext_pin_free_o(ext_pin_free_o));
`default_nettype wire

// ===== sbrg_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// far side: pin clock source, tick tally
// ****************************************
module sbrg_far_model (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  // control
  input  wire logic        run_i,
  input  wire logic [3:0]  half_i,
  input  wire logic        baud_tick_i,
  // pin and tally
  output var  logic        pin_o,
  output var  logic [15:0] ticks_o
);
  logic [3:0] cnt;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 4'h0;
      pin_o <= 1'b0;
      ticks_o <= 16'h0000;
    end else begin
      ticks_o <= ticks_o + {15'h0000, baud_tick_i};
      if (!run_i) begin
        cnt <= 4'h0;
        pin_o <= 1'b0;
      end else if (cnt == half_i) begin
        cnt <= 4'h0;
        pin_o <= !pin_o;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== serial_baud_rate_generator_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbrg_defs.vh"
// ****************************************
// register and rate tests
// ****************************************
module serial_baud_rate_generator_tb;
  localparam logic [31:0] A_DIV = {14'h0000, `SBRG_ADDR_DIVCTL};
  localparam logic [31:0] A_SRC = {14'h0000, `SBRG_ADDR_CLKSRC};
  logic        clk, rst_n, psel, pen, pwr, pready, pslverr, pin, bclk, btick, pfree, run, rerr;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [3:0]  pstrb, half;
  logic [15:0] ticks, n0;
  logic [7:0]  dv [6] = '{8'h50, 8'h5E, 8'h61, 8'h5F, 8'h73, 8'h00};
  logic        hv [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  int          num_errors = 0;
  int          checks = 0;
  sbrg_top sbrg_top_inst (.sys_clk_i(clk), .arst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .external_baud_clock_pin_i(pin),
    .baud_clk_o(bclk), .baud_tick_o(btick), .ext_pin_free_o(pfree));
  sbrg_far_model sbrg_far_model_inst (.sys_clk_i(clk), .arst_n_i(rst_n), .run_i(run),
    .half_i(half), .baud_tick_i(btick), .pin_o(pin), .ticks_o(ticks));
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  task results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    int i;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (i == 50) begin
      num_errors++;
      results();
    end
    @(posedge clk);
  endtask
  function automatic int gap(input logic [7:0] v, input logic h);
    int n;
    n = (v[7:4] == 4'h0) ? 11 : v[7:4] - 4;
    return ((v[3:0] == 4'hF) ? 1 : v[3:0] + 16) * (1 << (n - 1)) * (h ? 1 : 2);
  endfunction
  task automatic measure(input int e, input string nm);
    int i;
    int c;
    logic b;
    i = 0;
    while (btick !== 1'b1 && i < 40000) begin
      @(posedge clk);
      i++;
    end
    b = bclk;
    @(posedge clk);
    c = 1;
    while (btick !== 1'b1 && c < 40000) begin
      @(posedge clk);
      c++;
    end
    chk(nm, e, c);
    chk("clk toggle", {31'h0, ~b}, {31'h0, bclk});
    if (i >= 40000 || c >= 40000) begin
      num_errors++;
      results();
    end
  endtask
  initial begin
    {rst_n, psel, pen, pwr, run} = 5'h00;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    half = 4'h2;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, A_DIV, 32'h0, 4'hF);
    chk("div reset", 32'h00, rdat);
    apb(1'b0, A_SRC, 32'h0, 4'hF);
    chk("src reset", 32'h00, rdat);
    apb(1'b1, A_DIV, 32'hA5, 4'hF);
    apb(1'b1, A_DIV, 32'hFF, 4'h0);
    apb(1'b0, A_DIV, 32'h0, 4'hF);
    chk("div rw", 32'hA5, rdat);
    apb(1'b0, 32'h00000010, 32'h0, 4'hF);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    apb(1'b1, A_SRC, 32'h3, 4'hF);
    repeat (2) @(posedge clk);
    chk("pin free", 32'h1, {31'h0, pfree});
    for (int t = 0; t < 6; t++) begin
      apb(1'b1, A_SRC, {30'h0, 1'b1, hv[t]}, 4'hF);
      apb(1'b1, A_DIV, {24'h0, dv[t]}, 4'hF);
      measure(gap(dv[t], hv[t]), "tick gap");
    end
    apb(1'b1, A_DIV, 32'h10, 4'hF);
    repeat (2) @(posedge clk);
    n0 = ticks;
    repeat (300) @(posedge clk);
    chk("prohibited", {16'h0, n0}, {16'h0, ticks});
    apb(1'b1, A_SRC, 32'h1, 4'hF);
    run <= 1'b1;
    apb(1'b1, A_DIV, 32'h12, 4'hF);
    chk("pin used", 32'h0, {31'h0, pfree});
    measure(18 * 6, "ext gap");
    results();
  end
endmodule
`default_nettype wire
